// File: inc/cmp_pkg.sv
// constants for the comparator control and status block
`default_nettype none
package cmp_pkg;
   // ************************************************
   // register bus and map
   // ************************************************
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 16;
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_CLEAR = 2'h2;
   localparam logic [1:0] ADDR_IRQ_EN = 2'h3;
   // ************************************************
   // control register fields
   // ************************************************
   localparam int unsigned BIT_ON = 15;
   localparam int unsigned BIT_PIN_EN = 14;
   localparam int unsigned BIT_POL = 13;
   localparam int unsigned BIT_EVT = 9;
   localparam int unsigned BIT_RESULT = 8;
   localparam int unsigned EDGE_LSB = 6;
   localparam int unsigned EDGE_MSB = 7;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ************************************************
   // status and interrupt fields
   // ************************************************
   localparam int unsigned STAT_EVT = 0;
   localparam logic IRQ_EN_RESET = 1'h0;
   // event edge choice, relative to the raw comparison
   typedef enum logic [1:0] {
      CMP_EDGE_OFF = 2'b00,
      CMP_EDGE_RISE = 2'b01,
      CMP_EDGE_FALL = 2'b10,
      CMP_EDGE_ANY = 2'b11
   } cmp_edge_e;
endpackage
`default_nettype wire

// File: rtl/cmp_edge_detect.sv
// edge detector on the raw comparison for event generation
`default_nettype none
module cmp_edge_detect (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rawCompare,
   input wire cmp_pkg::cmp_edge_e edgeSel,
   output logic edgeHit
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic rawPrev;
   } cmp_det_s;

   cmp_det_s st_r;
   cmp_det_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rawPrev = rawCompare;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // edges are taken on the raw signal, so a fall stays a fall whatever the polarity
   always_comb begin
      case (edgeSel)
         cmp_pkg::CMP_EDGE_RISE: edgeHit = rawCompare & ~st_r.rawPrev;
         cmp_pkg::CMP_EDGE_FALL: edgeHit = ~rawCompare & st_r.rawPrev;
         cmp_pkg::CMP_EDGE_ANY: edgeHit = rawCompare ^ st_r.rawPrev;
         default: edgeHit = 1'b0;
      endcase
   end

   a_edge_rise: assert property (@(posedge clk) disable iff (!rst_n)
      (edgeSel == cmp_pkg::CMP_EDGE_RISE && edgeHit) |-> (rawCompare && !$past(rawCompare)))
      else $error("rise hit without a rising raw edge");
   a_edge_off: assert property (@(posedge clk) disable iff (!rst_n)
      (edgeSel == cmp_pkg::CMP_EDGE_OFF) |-> !edgeHit)
      else $error("edge hit while event generation is off");
endmodule
`default_nettype wire

// File: rtl/cmp_ctrl.sv
// comparator channel control, result routing, event flag and interrupt
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module cmp_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdata,
   input wire logic rawCompare,
   output logic resultPin,
   output logic resultPinOe_n,
   output logic eventTrigger,
   output logic irq
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic comparatorOn;
      logic outputPinEnable;
      logic outputPolarityInvert;
      cmp_pkg::cmp_edge_e eventEdgeSelect;
      logic eventFlag;
      logic compareResult;
      logic statusEvt;
      logic irqEn;
      logic pin;
      logic [15:0] rdata;
   } cmp_state_s;

   cmp_state_s st_r;
   cmp_state_s st_nxt;
   logic edgeHit;
   logic evtAccept;
   logic ctrlWr;
   logic clearWr;
   logic [15:0] ctrlView;

   cmp_edge_detect u_edge (
      .clk(clk),
      .rst_n(rst_n),
      .rawCompare(rawCompare),
      .edgeSel(st_r.eventEdgeSelect),
      .edgeHit(edgeHit)
   );

   // ************************************************
   // event qualification
   // ************************************************
   // flag blocks triggers
   assign evtAccept = edgeHit & st_r.comparatorOn & ~st_r.eventFlag;
   assign eventTrigger = evtAccept;
   assign ctrlWr = regWrite && (regAddr == cmp_pkg::ADDR_CTRL);
   assign clearWr = regWrite && (regAddr == cmp_pkg::ADDR_CLEAR);

   always_comb begin
      ctrlView = '0;
      ctrlView[cmp_pkg::BIT_ON] = st_r.comparatorOn;
      ctrlView[cmp_pkg::BIT_PIN_EN] = st_r.outputPinEnable;
      ctrlView[cmp_pkg::BIT_POL] = st_r.outputPolarityInvert;
      ctrlView[cmp_pkg::BIT_EVT] = st_r.eventFlag;
      ctrlView[cmp_pkg::BIT_RESULT] = st_r.compareResult;
      ctrlView[cmp_pkg::EDGE_MSB:cmp_pkg::EDGE_LSB] = st_r.eventEdgeSelect;
   end

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      st_nxt = st_r;
      if (ctrlWr) begin
         st_nxt.comparatorOn = regWdata[cmp_pkg::BIT_ON];
         st_nxt.outputPinEnable = regWdata[cmp_pkg::BIT_PIN_EN];
         st_nxt.outputPolarityInvert = regWdata[cmp_pkg::BIT_POL];
         st_nxt.eventEdgeSelect = cmp_pkg::cmp_edge_e'(regWdata[cmp_pkg::EDGE_MSB:cmp_pkg::EDGE_LSB]);
         // software can only clear the flag; writing one leaves it alone
         if (!regWdata[cmp_pkg::BIT_EVT]) begin
            st_nxt.eventFlag = 1'b0;
         end
      end
      if (regAddr == cmp_pkg::ADDR_IRQ_EN && regWrite) begin
         st_nxt.irqEn = regWdata[cmp_pkg::STAT_EVT];
      end
      if (clearWr && regWdata[cmp_pkg::STAT_EVT]) begin
         st_nxt.statusEvt = 1'b0;
      end
      // set flag, set wins over clear
      if (evtAccept) begin
         st_nxt.eventFlag = 1'b1;
         st_nxt.statusEvt = 1'b1;
      end
      st_nxt.compareResult = st_r.comparatorOn & (rawCompare ^ st_r.outputPolarityInvert);
      // pin follows result
      // next enable used so a released pin never shows a stale high
      st_nxt.pin = st_nxt.outputPinEnable & st_nxt.compareResult;
      st_nxt.rdata = '0;
      if (regRead) begin
         case (regAddr)
            cmp_pkg::ADDR_CTRL: st_nxt.rdata = ctrlView;
            cmp_pkg::ADDR_STATUS: st_nxt.rdata = {15'h0000, st_r.statusEvt};
            cmp_pkg::ADDR_IRQ_EN: st_nxt.rdata = {15'h0000, st_r.irqEn};
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{
            comparatorOn: cmp_pkg::CTRL_RESET[cmp_pkg::BIT_ON],
            outputPinEnable: cmp_pkg::CTRL_RESET[cmp_pkg::BIT_PIN_EN],
            outputPolarityInvert: cmp_pkg::CTRL_RESET[cmp_pkg::BIT_POL],
            eventEdgeSelect: cmp_pkg::CMP_EDGE_OFF,
            eventFlag: cmp_pkg::CTRL_RESET[cmp_pkg::BIT_EVT],
            compareResult: cmp_pkg::CTRL_RESET[cmp_pkg::BIT_RESULT],
            statusEvt: 1'b0,
            irqEn: cmp_pkg::IRQ_EN_RESET,
            pin: 1'b0,
            rdata: 16'h0000
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign regRdata = st_r.rdata;
   assign resultPin = st_r.pin;
   assign resultPinOe_n = ~st_r.outputPinEnable;
   assign irq = st_r.statusEvt & st_r.irqEn;

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_pin_follows_result: assert property (
      (!resultPinOe_n && st_r.comparatorOn && $past(st_r.outputPinEnable)) |-> resultPin == st_r.compareResult)
      else $error("pin does not follow the result");
   a_pin_released: assert property (
      resultPinOe_n |-> !resultPin)
      else $error("pin high while not driven");
   a_polarity_inverts: assert property (
      (st_r.comparatorOn && st_r.outputPolarityInvert && !ctrlWr) |=> st_r.compareResult == !$past(rawCompare))
      else $error("inverted result wrong");
   a_reserved_zero: assert property (
      (regRead && regAddr == cmp_pkg::ADDR_CTRL) |=> regRdata[12:10] == 3'h0)
      else $error("reserved bits not zero");
   a_flag_sets: assert property (
      evtAccept |=> st_r.eventFlag && st_r.statusEvt)
      else $error("event flag not set");
   a_flag_blocks: assert property (
      st_r.eventFlag |-> !eventTrigger)
      else $error("trigger while flag set");
   a_flag_holds: assert property (
      (st_r.eventFlag && !ctrlWr) |=> st_r.eventFlag)
      else $error("flag lost without a clear");
   a_result_read: assert property (
      (regRead && regAddr == cmp_pkg::ADDR_CTRL) |=> regRdata[8] == $past(st_r.compareResult))
      else $error("result bit read wrong");
   a_plain_result: assert property (
      (st_r.comparatorOn && !st_r.outputPolarityInvert && !ctrlWr) |=> st_r.compareResult == $past(rawCompare))
      else $error("plain result wrong");
   a_off_quiet: assert property (
      !st_r.comparatorOn |-> !eventTrigger ##1 !st_r.compareResult)
      else $error("activity while comparator is off");
   a_inverted_pin: assert property (
      (st_r.outputPinEnable && st_r.comparatorOn && st_r.outputPolarityInvert && !ctrlWr)
      |=> resultPin == !$past(rawCompare))
      else $error("pin not inverted with the result");
   a_irq_level: assert property (
      irq == (st_r.statusEvt && st_r.irqEn))
      else $error("irq level wrong");
   a_status_source: assert property (
      (!st_r.statusEvt && !evtAccept) |=> !st_r.statusEvt)
      else $error("status set without an accepted event");
   a_status_clears: assert property (
      (clearWr && regWdata[cmp_pkg::STAT_EVT] && !evtAccept) |=> !st_r.statusEvt)
      else $error("status not cleared by the clear register");
   a_flag_clears: assert property (
      (ctrlWr && !regWdata[cmp_pkg::BIT_EVT] && !evtAccept) |=> !st_r.eventFlag)
      else $error("flag not cleared by a control write");
   a_reserved_low: assert property (
      (regRead && regAddr == cmp_pkg::ADDR_CTRL) |=> regRdata[5:0] == 6'h00)
      else $error("low unused bits not zero");
   a_rdata_idle: assert property (
      !regRead |=> regRdata == 16'h0000)
      else $error("read data present without a read");

   // ************************************************
   // cover points
   // ************************************************
   c_event_taken: cover property (evtAccept ##1 irq);
   c_fall_event: cover property (evtAccept && st_r.eventEdgeSelect == cmp_pkg::CMP_EDGE_FALL);
   c_event_blocked: cover property (st_r.eventFlag && edgeHit && st_r.comparatorOn);
   c_clear_rearm: cover property (st_r.eventFlag ##1 !st_r.eventFlag ##[1:20] evtAccept);
   c_pin_inverted: cover property (!resultPinOe_n && st_r.outputPolarityInvert && resultPin);
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the comparator control and status block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // signals and design
   // ****************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic rawCompare = 1'b0;
   logic [15:0] regRdata;
   logic resultPin;
   logic resultPinOe_n;
   logic eventTrigger;
   logic irq;
   logic [15:0] ctrl;
   logic [1:0] e;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   cmp_ctrl cmp_ctrl_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rawCompare(rawCompare),
      .resultPin(resultPin), .resultPinOe_n(resultPinOe_n), .eventTrigger(eventTrigger), .irq(irq));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic wrap_up();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // a hung sequence still reaches the verdict
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures = failures + 1;
         wrap_up();
      end
   end
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ends at a falling edge so flags are sampled once settled
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk16(regRdata, exp);
   endtask
   task automatic setRaw(input logic v, input logic expTrig);
      @(posedge clk);
      rawCompare <= v;
      @(negedge clk);
      chk1(eventTrigger, expTrig);
   endtask
   // flag cleared by writing bit 9 low, sticky status by the clear register
   task automatic clearEvt(input logic [15:0] c);
      wr(cmp_pkg::ADDR_CTRL, c);
      wr(cmp_pkg::ADDR_CLEAR, 16'h0001);
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (11) @(posedge clk);
      @(negedge clk);
      chk1(resultPinOe_n, 1'b1);
      chk1(irq, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      rd(cmp_pkg::ADDR_CTRL, 16'h0000);
      // unimplemented bits and inverted result
      wr(cmp_pkg::ADDR_CTRL, 16'hffff);
      rd(cmp_pkg::ADDR_CTRL, 16'he1c0);
      chk1(resultPinOe_n, 1'b0);
      chk1(resultPin, 1'b1);
      rd(cmp_pkg::ADDR_CLEAR, 16'h0000);
      // raw edge with inversion: pin and result drop, flag set
      setRaw(1'b1, 1'b1);
      rd(cmp_pkg::ADDR_CTRL, 16'he2c0);
      chk1(resultPin, 1'b0);
      setRaw(1'b0, 1'b0);
      wr(cmp_pkg::ADDR_CLEAR, 16'h0001);
      chk1(resultPin, 1'b1);
      // comparator off hides result and events
      wr(cmp_pkg::ADDR_CTRL, 16'h4040);
      setRaw(1'b1, 1'b0);
      rd(cmp_pkg::ADDR_CTRL, 16'h4040);
      chk1(resultPin, 1'b0);
      setRaw(1'b0, 1'b0);
      wr(cmp_pkg::ADDR_IRQ_EN, 16'h0001);
      rd(cmp_pkg::ADDR_IRQ_EN, 16'h0001);
      // every edge selection code
      for (int c = 0; c < 4; c++) begin
         e = 2'(c);
         ctrl = {8'h80, e, 6'h00};
         wr(cmp_pkg::ADDR_CTRL, ctrl);
         setRaw(1'b1, e[0]);
         rd(cmp_pkg::ADDR_CTRL, {ctrl[15:10], e[0], 1'b1, ctrl[7:0]});
         chk1(irq, e[0]);
         clearEvt(ctrl);
         setRaw(1'b0, e[1]);
         rd(cmp_pkg::ADDR_STATUS, {15'h0000, e[1]});
         clearEvt(ctrl);
         chk1(irq, 1'b0);
      end
      // set flag blocks further events until cleared
      wr(cmp_pkg::ADDR_CTRL, 16'hc040);
      setRaw(1'b1, 1'b1);
      rd(cmp_pkg::ADDR_CTRL, 16'hc340);
      chk1(resultPin, 1'b1);
      setRaw(1'b0, 1'b0);
      setRaw(1'b1, 1'b0);
      rd(cmp_pkg::ADDR_STATUS, 16'h0001);
      wr(cmp_pkg::ADDR_STATUS, 16'h0000);
      rd(cmp_pkg::ADDR_STATUS, 16'h0001);
      wr(cmp_pkg::ADDR_IRQ_EN, 16'h0000);
      chk1(irq, 1'b0);
      wr(cmp_pkg::ADDR_IRQ_EN, 16'h0001);
      chk1(irq, 1'b1);
      clearEvt(16'hc040);
      chk1(irq, 1'b0);
      setRaw(1'b0, 1'b0);
      setRaw(1'b1, 1'b1);
      rd(cmp_pkg::ADDR_CTRL, 16'hc340);
      wrap_up();
   end
endmodule
`default_nettype wire
